// ### rtl/slcd_cfg.svh
// Offsets, field positions, reset values and timing counts of the LCD block
`ifndef SLCD_CFG_SVH
`define SLCD_CFG_SVH
`define SLCD_IDX_PORT_CTRL 16'hFFC0
`define SLCD_IDX_CTRL 16'hFFC1
`define SLCD_IDX_CTRL2 16'hFFC2
`define SLCD_IDX_RAM_BASE 16'hF740
`define SLCD_RAM_BYTES 32
`define SLCD_RST_PORT_CTRL 8'h00
`define SLCD_RST_CTRL 8'h80
`define SLCD_RST_CTRL2 8'h60
`define SLCD_CTRL_FIXED_MASK 8'h80
`define SLCD_CTRL2_FIXED_MASK 8'h60
`define SLCD_PC_DUTY_HI 7
`define SLCD_PC_DUTY_LO 6
`define SLCD_PC_CMX 5
`define SLCD_PC_SGX 4
`define SLCD_C_PSW 6
`define SLCD_C_ACT 5
`define SLCD_C_SHOW_RAM_CONTENTS 4
`define SLCD_C2_WAVE 7
`define SLCD_C2_SUPS 4
`define SLCD_REF_CLK_HZ 100000000
`define SLCD_SUB_CLK_HZ 32768
`define SLCD_EXP_CAP_STATIC 9'd256
`define SLCD_EXP_CAP_HALF 9'd128
`define SLCD_EXP_CAP_MULTI 9'd64
`endif

// ### rtl/slcd_pkg.sv
// Types shared by the segment LCD controller
package slcd_pkg;
  typedef enum logic [1:0] {
    SLCD_DUTY_STATIC = 2'b00,
    SLCD_DUTY_HALF = 2'b01,
    SLCD_DUTY_THIRD = 2'b10,
    SLCD_DUTY_QUARTER = 2'b11
  } slcd_duty_t;
  typedef enum logic [1:0] {
    SLCD_EXP_IDLE = 2'b00,
    SLCD_EXP_SHIFT = 2'b01,
    SLCD_EXP_LATCH = 2'b10
  } slcd_exp_state_t;
  typedef struct packed {
    logic latch_clock;
    logic expansion_shift_clock;
    logic serial_data;
    logic alternation;
  } slcd_exp_t;
endpackage

// ### rtl/slcd_top.sv
// Segment LCD controller/driver with Avalon-MM register and RAM access
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "slcd_cfg.svh"
`default_nettype none
module slcd_top
  import slcd_pkg::*;
#(
  parameter int SUB_DIV = `SLCD_REF_CLK_HZ / `SLCD_SUB_CLK_HZ
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [17:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic CHIP_STANDBY,
  input wire logic MODULE_STANDBY,
  output logic [31:0] SEG_OUT,
  output logic [3:0] SEG_GROUP_DRIVER,
  output logic EXP_PINS_ACTIVE,
  output logic [3:0] COM_OUT,
  output logic LCD_ALT,
  output logic DRIVE_SUPPLY_ON,
  output logic BOOST_SUPPLY_ON
);
  logic [7:0] port_ctrl_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl2_reg;
  logic [255:0] ram_reg;
  logic [16:0] div_cnt_reg;
  logic op_tick;
  logic [1:0] slot_reg;
  logic pol_reg;
  logic [31:0] seg_next;
  logic [3:0] com_next;
  slcd_exp_state_t exp_state_reg;
  logic [8:0] exp_cnt_reg;
  logic [8:0] exp_cap;
  slcd_exp_t exp_reg;
  logic running;
  logic req;
  logic [15:0] idx;
  logic in_ram;
  logic [4:0] ram_idx;
  slcd_duty_t duty;
  logic frame_end;

  // Frame clock divisor per selection: three sub clock and eight system
  // clock rates, eleven in all
  function automatic logic [16:0] op_div(input logic [3:0] cks);
    logic [16:0] d;
    d = 17'h00001;
    if (!cks[3])
    begin
      if (cks[1])
        d = 17'(SUB_DIV * 4);
      else if (cks[0])
        d = 17'(SUB_DIV * 2);
      else
        d = 17'(SUB_DIV);
    end
    else
      d = 17'h00002 << cks[2:0];
    return d;
  endfunction

  // Bit position in the display RAM for a segment at a given slot
  function automatic logic [7:0] bit_pos(input logic [7:0] seg,
                                         input logic [1:0] slot,
                                         input slcd_duty_t dt);
    logic [7:0] p;
    p = 8'h00;
    case (dt)
      SLCD_DUTY_STATIC: p = seg;
      SLCD_DUTY_HALF: p = {seg[6:0], slot[0]};
      SLCD_DUTY_THIRD: p = {seg[5:0], slot};
      SLCD_DUTY_QUARTER: p = {seg[5:0], slot};
      default: p = seg;
    endcase
    return p;
  endfunction

  assign duty = slcd_duty_t'({port_ctrl_reg[`SLCD_PC_DUTY_HI],
                              port_ctrl_reg[`SLCD_PC_DUTY_LO]});
  // Either standby or display function off stops the scan
  assign running = ctrl_reg[`SLCD_C_ACT] && !CHIP_STANDBY && !MODULE_STANDBY;
  assign req = AVS_READ || AVS_WRITE;
  assign idx = AVS_ADDRESS[17:2];
  assign in_ram = (idx[15:5] == 11'(`SLCD_IDX_RAM_BASE >> 5));
  assign ram_idx = idx[4:0];
  assign frame_end = (slot_reg == duty);

  // One wait cycle per access; the answer comes on the second edge
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !(req && AVS_WAITREQUEST);
  end

  // Control registers; fixed bits keep their reset level
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      port_ctrl_reg <= `SLCD_RST_PORT_CTRL;
      ctrl_reg <= `SLCD_RST_CTRL;
      ctrl2_reg <= `SLCD_RST_CTRL2;
    end
    else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0])
    begin
      if (idx == `SLCD_IDX_PORT_CTRL)
        port_ctrl_reg <= AVS_WRITEDATA[7:0];
      if (idx == `SLCD_IDX_CTRL)
        ctrl_reg <= AVS_WRITEDATA[7:0] | `SLCD_CTRL_FIXED_MASK;
      if (idx == `SLCD_IDX_CTRL2)
        ctrl2_reg <= AVS_WRITEDATA[7:0] | `SLCD_CTRL2_FIXED_MASK;
    end
  end

  // Display RAM: lane 0 writes one byte; lanes 1:0 at an even index
  // write a word, high byte to the even address
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      ram_reg <= '0;
    else if (AVS_WRITE && !AVS_WAITREQUEST && in_ram)
    begin
      if (AVS_BYTEENABLE[1:0] == 2'b11 && !ram_idx[0])
      begin
        ram_reg[{ram_idx, 3'b000} +: 8] <= AVS_WRITEDATA[15:8];
        ram_reg[{ram_idx | 5'h01, 3'b000} +: 8] <= AVS_WRITEDATA[7:0];
      end
      else if (AVS_BYTEENABLE[0])
        ram_reg[{ram_idx, 3'b000} +: 8] <= AVS_WRITEDATA[7:0];
    end
  end

  // Read data; unmapped addresses answer zero
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      AVS_READDATA <= 32'h00000000;
    else if (AVS_READ && AVS_WAITREQUEST)
    begin
      AVS_READDATA <= 32'h00000000;
      if (idx == `SLCD_IDX_PORT_CTRL)
        AVS_READDATA <= {24'h000000, port_ctrl_reg};
      else if (idx == `SLCD_IDX_CTRL)
        AVS_READDATA <= {24'h000000, ctrl_reg};
      else if (idx == `SLCD_IDX_CTRL2)
        AVS_READDATA <= {24'h000000, ctrl2_reg};
      else if (in_ram && AVS_BYTEENABLE[1:0] == 2'b11 && !ram_idx[0])
        AVS_READDATA <= {16'h0000, ram_reg[{ram_idx, 3'b000} +: 8],
                         ram_reg[{ram_idx | 5'h01, 3'b000} +: 8]};
      else if (in_ram)
        AVS_READDATA <= {24'h000000, ram_reg[{ram_idx, 3'b000} +: 8]};
    end
  end

  // Frame clock divider
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      div_cnt_reg <= 17'h00000;
    else if (!running || op_tick)
      div_cnt_reg <= 17'h00000;
    else
      div_cnt_reg <= div_cnt_reg + 17'h00001;
  end
  assign op_tick = running && (div_cnt_reg >= op_div(ctrl_reg[3:0]) - 17'h1);

  // Slot sequencing and alternation; A flips per slot, B per frame
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      slot_reg <= 2'b00;
      pol_reg <= 1'b0;
    end
    else if (op_tick)
    begin
      slot_reg <= frame_end ? 2'b00 : slot_reg + 2'b01;
      if (!ctrl2_reg[`SLCD_C2_WAVE] || frame_end)
        pol_reg <= !pol_reg;
    end
  end

  // Segment and common levels for the current slot
  always_comb
  begin
    seg_next = 32'h00000000;
    com_next = 4'h0;
    for (int i = 0; i < 32; i++)
      seg_next[i] = ctrl_reg[`SLCD_C_SHOW_RAM_CONTENTS] &&
        ram_reg[bit_pos(8'(i), slot_reg, duty)];
    com_next[slot_reg] = 1'b1;
    if (port_ctrl_reg[`SLCD_PC_CMX] && duty == SLCD_DUTY_STATIC)
      com_next = 4'hF;
    else if (port_ctrl_reg[`SLCD_PC_CMX] && duty == SLCD_DUTY_HALF)
      com_next = {com_next[1:0], com_next[1:0]};
    if (port_ctrl_reg[`SLCD_PC_SGX])
      seg_next[31:28] = exp_reg;
    if (!running)
    begin
      seg_next = 32'h00000000;
      com_next = 4'h0;
    end
  end

  // Pin outputs; groups of eight pins set to port function stay low
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SEG_OUT <= 32'h00000000;
      COM_OUT <= 4'h0;
      LCD_ALT <= 1'b0;
    end
    else
    begin
      for (int g = 0; g < 4; g++)
        SEG_OUT[g*8 +: 8] <= SEG_GROUP_DRIVER[g] ?
          seg_next[g*8 +: 8] : 8'h00;
      if (port_ctrl_reg[`SLCD_PC_SGX])
        SEG_OUT[31:28] <= seg_next[31:28];
      COM_OUT <= com_next;
      LCD_ALT <= pol_reg && running;
    end
  end

  // Segment group driver enables, highest group first
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SEG_GROUP_DRIVER <= 4'h0;
      EXP_PINS_ACTIVE <= 1'b0;
    end
    else
    begin
      EXP_PINS_ACTIVE <= port_ctrl_reg[`SLCD_PC_SGX];
      if (port_ctrl_reg[`SLCD_PC_SGX] || !port_ctrl_reg[3] && !port_ctrl_reg[2]
          && !port_ctrl_reg[1])
        SEG_GROUP_DRIVER <= 4'h0;
      else if (port_ctrl_reg[3])
        SEG_GROUP_DRIVER <= 4'hF;
      else
        case (port_ctrl_reg[2:1])
          2'b01: SEG_GROUP_DRIVER <= 4'h8;
          2'b10: SEG_GROUP_DRIVER <= 4'hC;
          2'b11: SEG_GROUP_DRIVER <= 4'hE;
          default: SEG_GROUP_DRIVER <= 4'h0;
        endcase
    end
  end

  // Drive supply follows the switch only while the display function runs
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DRIVE_SUPPLY_ON <= 1'b0;
      BOOST_SUPPLY_ON <= 1'b0;
    end
    else
    begin
      DRIVE_SUPPLY_ON <= running && ctrl_reg[`SLCD_C_PSW];
      BOOST_SUPPLY_ON <= running && ctrl_reg[`SLCD_C_PSW] &&
        ctrl2_reg[`SLCD_C2_SUPS];
    end
  end

  // Bits shifted out per slot for the expansion driver
  always_comb
  begin
    case (duty)
      SLCD_DUTY_STATIC: exp_cap = `SLCD_EXP_CAP_STATIC;
      SLCD_DUTY_HALF: exp_cap = `SLCD_EXP_CAP_HALF;
      default: exp_cap = `SLCD_EXP_CAP_MULTI;
    endcase
  end

  // Expansion stream: each slot shifts its bits, then one latch pulse.
  // A slot shorter than the stream restarts it; pick a slow frame rate.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      exp_state_reg <= SLCD_EXP_IDLE;
      exp_cnt_reg <= 9'h000;
      exp_reg <= '0;
    end
    else if (!running || !port_ctrl_reg[`SLCD_PC_SGX])
    begin
      exp_state_reg <= SLCD_EXP_IDLE;
      exp_cnt_reg <= 9'h000;
      exp_reg <= '0;
    end
    else
    begin
      exp_reg.alternation <= pol_reg;
      if (op_tick)
      begin
        exp_state_reg <= SLCD_EXP_SHIFT;
        exp_cnt_reg <= 9'h000;
        exp_reg.expansion_shift_clock <= 1'b0;
        exp_reg.latch_clock <= 1'b0;
      end
      else
        case (exp_state_reg)
          SLCD_EXP_IDLE:
          begin
            exp_reg.latch_clock <= 1'b0;
          end
          SLCD_EXP_SHIFT:
          begin
            if (!exp_reg.expansion_shift_clock)
            begin
              exp_reg.serial_data <= ctrl_reg[`SLCD_C_SHOW_RAM_CONTENTS] &&
                ram_reg[bit_pos(exp_cnt_reg[7:0], slot_reg, duty)];
              exp_reg.expansion_shift_clock <= 1'b1;
            end
            else
            begin
              exp_reg.expansion_shift_clock <= 1'b0;
              exp_cnt_reg <= exp_cnt_reg + 9'h001;
              if (exp_cnt_reg == exp_cap - 9'h001)
                exp_state_reg <= SLCD_EXP_LATCH;
            end
          end
          SLCD_EXP_LATCH:
          begin
            exp_reg.latch_clock <= 1'b1;
            exp_state_reg <= SLCD_EXP_IDLE;
          end
          default: exp_state_reg <= SLCD_EXP_IDLE;
        endcase
    end
  end
endmodule
`default_nettype wire

// ### verification/slcd_panel_model.sv
// Panel model: keeps the segment image lit under each common
`timescale 1ns/1ps
`default_nettype none
module slcd_panel_model
  import slcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] seg,
  input wire logic [3:0] com,
  output logic [31:0] lit [4]
);
  // Only a lone active common updates an image, so parallel drive is ignored
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < 4; c++) lit[c] <= '0;
    end
    else
    begin
      for (int c = 0; c < 4; c++)
        if (com == 4'(1 << c))
          lit[c] <= seg;
    end
  end
endmodule
`default_nettype wire

// ### verification/slcd_props.sv
// Port checker for the segment LCD controller
`timescale 1ns/1ps
`default_nettype none
module slcd_props
  import slcd_pkg::*;
#(
  parameter int SUB_DIV = 4
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [17:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic CHIP_STANDBY,
  input wire logic MODULE_STANDBY,
  input wire logic [31:0] SEG_OUT,
  input wire logic [3:0] SEG_GROUP_DRIVER,
  input wire logic EXP_PINS_ACTIVE,
  input wire logic [3:0] COM_OUT,
  input wire logic LCD_ALT,
  input wire logic DRIVE_SUPPLY_ON,
  input wire logic BOOST_SUPPLY_ON
);
  wire logic [31:0] grp_mask;
  assign grp_mask = {{8{SEG_GROUP_DRIVER[3]}}, {8{SEG_GROUP_DRIVER[2]}},
                     {8{SEG_GROUP_DRIVER[1]}}, {8{SEG_GROUP_DRIVER[0]}}};
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  req_answer_a: assert property ((AVS_READ || AVS_WRITE) &&
    AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered after one wait cycle");
  wait_pulse_a: assert property (!AVS_WAITREQUEST |=>
    AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  unmapped_read_a: assert property (AVS_READ && AVS_WAITREQUEST &&
    AVS_ADDRESS[17:16] == 2'b00 |=> AVS_READDATA == 32'h0)
    else $error("unmapped read returned data");
  mod_standby_a: assert property (MODULE_STANDBY [*3] |->
    COM_OUT == 4'h0 && SEG_OUT == 32'h0 && !DRIVE_SUPPLY_ON)
    else $error("display active in module standby");
  chip_standby_a: assert property (CHIP_STANDBY [*3] |->
    COM_OUT == 4'h0 && !DRIVE_SUPPLY_ON)
    else $error("display active in chip standby");
  boost_dep_a: assert property (BOOST_SUPPLY_ON |->
    DRIVE_SUPPLY_ON)
    else $error("boost supply on without drive supply");
  com_shape_a: assert property (COM_OUT inside
    {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'hA, 4'hF})
    else $error("illegal common pattern");
  // A register write may move the commons at once and standby blanks them,
  // so only slot steps away from those events are held to two cycles
  com_hold_a: assert property ($changed(COM_OUT) && COM_OUT != 4'h0 &&
    !$past(AVS_WRITE) && !$past(AVS_WRITE, 2) |=>
    $stable(COM_OUT) || CHIP_STANDBY || MODULE_STANDBY)
    else $error("common slot shorter than two cycles");
  exp_ports_a: assert property (EXP_PINS_ACTIVE [*3] |->
    SEG_OUT[27:0] == 28'h0)
    else $error("segment drive on port pins in expansion mode");
  group_port_a: assert property ((!EXP_PINS_ACTIVE &&
    $stable(SEG_GROUP_DRIVER)) [*3] |-> (SEG_OUT & ~grp_mask) == 32'h0)
    else $error("segment drive on a port group");
endmodule
bind slcd_top slcd_props #(.SUB_DIV(SUB_DIV)) slcd_props_i (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CHIP_STANDBY(CHIP_STANDBY),
  .MODULE_STANDBY(MODULE_STANDBY), .SEG_OUT(SEG_OUT),
  .SEG_GROUP_DRIVER(SEG_GROUP_DRIVER), .EXP_PINS_ACTIVE(EXP_PINS_ACTIVE),
  .COM_OUT(COM_OUT), .LCD_ALT(LCD_ALT), .DRIVE_SUPPLY_ON(DRIVE_SUPPLY_ON),
  .BOOST_SUPPLY_ON(BOOST_SUPPLY_ON));
`default_nettype wire

// ### verification/slcd_top_tb_top.sv
// Testbench for the segment LCD controller
`timescale 1ns/1ps
`default_nettype none
module slcd_top_tb_top
  import slcd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [17:0] addr = '0;
  logic rd = 1'b0, wr = 1'b0, chip_sb = 1'b0, mod_sb = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] be = '0;
  logic [31:0] rdata, seg, got, seg_or;
  logic [3:0] grp, com, com_or, pcom = '0;
  logic waitreq, exp_act, alt, drv_on, boost_on, palt = 1'b0, p30 = 1'b0;
  logic [31:0] lit [4];
  logic [7:0] ram_img [32];
  logic [7:0] fv [4] = '{8'h78, 8'h30, 8'h31, 8'h32};
  int fe [4] = '{128, 64, 32, 16};
  int n_mismatch = 0, checks = 0, chg = 0, af = 0, fb = 0, sh = 0, last_sh = 0;
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  slcd_top #(.SUB_DIV(4)) slcd_top_i (.REF_CLK(ref_clk), .RST_N(rst_n),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .CHIP_STANDBY(chip_sb), .MODULE_STANDBY(mod_sb), .SEG_OUT(seg),
    .SEG_GROUP_DRIVER(grp), .EXP_PINS_ACTIVE(exp_act), .COM_OUT(com),
    .LCD_ALT(alt), .DRIVE_SUPPLY_ON(drv_on), .BOOST_SUPPLY_ON(boost_on));
  slcd_panel_model slcd_panel_model_i (.clk(ref_clk), .rst_n(rst_n),
    .seg(seg), .com(com), .lit(lit));
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One bus access; a hung slave ends the run instead of stalling it
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    @(posedge ref_clk);
    rd <= !w;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= d;
    be <= b;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [15:0] m,
                       input logic [15:0] e);
    bus(1'b0, idx, 32'h0, 4'hF);
    cmp({16'h0, got[15:0] & m}, {16'h0, e});
  endtask
  // Skips ten cycles so outputs settle after a setting change
  task automatic watch(input int n);
    repeat (10) @(posedge ref_clk);
    com_or = '0;
    seg_or = '0;
    chg = 0;
    af = 0;
    repeat (n)
    begin
      @(posedge ref_clk);
      com_or = com_or | com;
      seg_or = seg_or | seg;
      chg += int'(com != pcom);
      af += int'(alt != palt);
      if (seg[30] && !p30) sh++;
      if (seg[31])
      begin
        last_sh = sh;
        sh = 0;
      end
      pcom = com;
      palt = alt;
      p30 = seg[30];
    end
  endtask
  function automatic logic [31:0] seg_exp(input int c);
    for (int s = 0; s < 32; s++)
      seg_exp[s] = ram_img[s / 2][(s % 2) * 4 + c];
  endfunction
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(16'hFFC0, 16'hFF, 16'h00);
    rdchk(16'hFFC1, 16'hFF, 16'h80);
    rdchk(16'hFFC2, 16'hFF, 16'h60);
    bus(1'b1, 16'hFFC2, 32'h90, 4'h1);
    rdchk(16'hFFC2, 16'hFF, 16'hF0);
    bus(1'b1, 16'h0000, 32'h55, 4'h1);
    rdchk(16'h0000, 16'hFFFF, 16'h0000);
    for (int k = 0; k < 32; k++)
      ram_img[k] = (k < 16) ? 8'(k * 37 + 5) : 8'h00;
    for (int k = 0; k < 16; k += 2)
      bus(1'b1, 16'hF740 + 16'(k), {16'h0, ram_img[k], ram_img[k + 1]},
          4'h3);
    ram_img[3] = 8'h4E;
    bus(1'b1, 16'hF743, 32'h4E, 4'h1);
    rdchk(16'hF742, 16'hFFFF, {ram_img[2], ram_img[3]});
    rdchk(16'hF745, 16'hFF, {8'h00, ram_img[5]});
    bus(1'b1, 16'hFFC0, 32'hC8, 4'h1);
    bus(1'b1, 16'hFFC1, 32'h79, 4'h1);
    watch(100);
    for (int c = 0; c < 4; c++)
      cmp(lit[c], seg_exp(c));
    cmp({28'h0, com_or}, 32'hF);
    cmp({30'h0, drv_on, boost_on}, 32'h3);
    cmp({28'h0, grp}, 32'hF);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 16'hFFC1, {24'h0, fv[i]}, 4'h1);
      watch(256);
      cmp(32'(chg >= fe[i] - 1 && chg <= fe[i] + 1), 32'h1);
    end
    bus(1'b1, 16'hFFC1, 32'h79, 4'h1);
    watch(200);
    fb = af;
    bus(1'b1, 16'hFFC2, 32'h10, 4'h1);
    watch(200);
    cmp(32'(fb > 0 && af > 2 * fb), 32'h1);
    for (int d = 0; d < 4; d++)
    begin
      bus(1'b1, 16'hFFC0, {24'h0, 2'(d), 6'h08}, 4'h1);
      watch(100);
      cmp({28'h0, com_or}, 32'((1 << (d + 1)) - 1));
    end
    for (int d = 0; d < 2; d++)
    begin
      bus(1'b1, 16'hFFC0, {24'h0, 2'(d), 6'h28}, 4'h1);
      watch(100);
      cmp({28'h0, com_or}, 32'hF);
    end
    bus(1'b1, 16'hFFC0, 32'hC2, 4'h1);
    watch(50);
    cmp({28'h0, grp}, 32'h8);
    bus(1'b1, 16'hFFC1, 32'h69, 4'h1);
    watch(50);
    cmp(seg_or, 32'h0);
    cmp(32'(com_or != 4'h0), 32'h1);
    bus(1'b1, 16'hFFC0, 32'hD0, 4'h1);
    bus(1'b1, 16'hFFC1, 32'h7F, 4'h1);
    watch(800);
    cmp({31'h0, exp_act}, 32'h1);
    cmp({30'h0, seg_or[31:30]}, 32'h3);
    cmp(32'(last_sh), 32'd64);
    mod_sb <= 1'b1;
    watch(20);
    cmp({27'h0, com_or, drv_on}, 32'h0);
    mod_sb <= 1'b0;
    chip_sb <= 1'b1;
    watch(20);
    cmp({27'h0, com_or, drv_on}, 32'h0);
    chip_sb <= 1'b0;
    bus(1'b1, 16'hFFC1, 32'h59, 4'h1);
    watch(20);
    cmp({27'h0, com_or, drv_on}, 32'h0);
    rdchk(16'hFFC1, 16'hFF, 16'hD9);
    rdchk(16'hFFC0, 16'hFF, 16'hD0);
    stop_test();
  end
endmodule
`default_nettype wire
